/* hw/adsq_buffer2.v */
// two-entry skid buffer with valid and ready on both sides
// assumes the drain side may stall for any length of time
`timescale 1ns/10ps
`default_nettype none

module adsq_buffer2 #(
    parameter WIDTH = 16
) (
    // clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // fill side
    input wire inValid,
    input wire [WIDTH-1:0] inData,
    output reg inReady,
    // drain side, both outputs from flops
    output reg outValid,
    output reg [WIDTH-1:0] outData,
    input wire outReady
);
    reg [WIDTH-1:0] skid_q;
    reg skidFull_q;
    wire pushOk;
    wire popOk;

    assign pushOk = inValid & inReady;
    assign popOk = outValid & outReady;

    // ==================================================
    // head register plus skid slot; ready drops only when both hold a word
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            outValid <= 1'b0;
            outData <= {WIDTH{1'b0}};
            skid_q <= {WIDTH{1'b0}};
            skidFull_q <= 1'b0;
            inReady <= 1'b1;
        end else begin
            if (!outValid || popOk) begin
                if (skidFull_q) begin
                    outData <= skid_q;
                    outValid <= 1'b1;
                    skidFull_q <= pushOk;
                    if (pushOk) begin
                        skid_q <= inData;
                    end
                end else begin
                    outValid <= pushOk;
                    if (pushOk) begin
                        outData <= inData;
                    end
                end
                inReady <= 1'b1;
            end else if (pushOk) begin
                skid_q <= inData;
                skidFull_q <= 1'b1;
                inReady <= 1'b0;
            end
        end
    end
endmodule // adsq_buffer2

`default_nettype wire

/* hw/adsq_edge_detect.v */
// edge detector with selectable polarity for a level already in the clk_sys domain
// assumes the input is synchronous to clk_sys
`timescale 1ns/10ps
`default_nettype none

module adsq_edge_detect (
    // clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // level in, polarity select, edge pulse out
    input wire levelIn,
    input wire fallingSel,
    output wire edgePulse
);
    reg level_q;

    // ==================================================
    // previous-level store
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            // start from the pin's own level so no false edge follows reset
            level_q <= levelIn;
        end else begin
            level_q <= levelIn;
        end
    end

    // select which transition counts
    assign edgePulse = fallingSel ? (level_q & ~levelIn) : (~level_q & levelIn);
endmodule // adsq_edge_detect

`default_nettype wire

/* hw/adsq_sequencer.v */
// scan list sequencer: list memory, trigger, pacing, sync pin and sample stream
// assumes an AHB-Lite master on the register side and a converter that answers
// each adcStart with one adcDone carrying a signed offset-from-mid-scale value
`include "adsq_defs.vh"
`timescale 1ns/10ps
`default_nettype none

module adsq_sequencer (
    // clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg [31:0] hrdata,
    output reg hresp,
    // trigger and sync pins
    input wire ext_trigger_input,
    input wire syncIn,
    output reg syncOut,
    output reg syncOeN,
    // converter
    output reg [2:0] adcChannel,
    output reg [2:0] adcRange,
    output reg adcStart,
    input wire adcDone,
    input wire signed [13:0] adcRaw,
    // sample stream: list index [15:12], code [11:0]
    output wire sampleValid,
    output wire [15:0] sampleData,
    input wire sampleReady
);
    // ==================================================
    // state codes
    localparam ST_IDLE = 3'h0;
    localparam ST_ARM = 3'h1;
    localparam ST_TICK = 3'h2;
    localparam ST_CONV = 3'h3;
    localparam ST_STORE = 3'h4;

    reg [2:0] state_q;
    reg [`ADSQ_CTRL_W-1:1] ctrl_q;
    reg [15:0] pacerDiv_q;
    reg [15:0] pacerCnt_q;
    reg [15:0] total_q;
    reg [15:0] done_q;
    reg [3:0] listLast_q;
    reg [3:0] ptr_q;
    reg [15:0] last_q;
    reg [11:0] code_q;
    reg firstSeen_q;
    reg [`ADSQ_ENT_W-1:0] listMem [0:15];
    reg wrPend_q;
    reg [7:0] wrAddr_q;
    reg startReq_q;
    reg abortReq_q;
    reg [7:0] rdAddr;
    reg [31:0] rdData;
    reg signed [13:0] sum;
    wire addrPhase;
    wire trigEdge;
    wire syncEdge;
    wire intTick;
    wire tick;
    wire bufReady;
    wire [`ADSQ_ENT_W-1:0] curEnt;
    wire [3:0] nextPtr;

    assign addrPhase = hsel & htrans[1] & hready;
    assign intTick = (pacerCnt_q == 16'h0000);
    assign curEnt = listMem[ptr_q];
    assign nextPtr = (ptr_q == listLast_q) ? 4'h0 : ptr_q + 4'h1;

    // ==================================================
    // trigger and sync edge detectors
    adsq_edge_detect uTrig (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .levelIn(ext_trigger_input),
        .fallingSel(ctrl_q[`ADSQ_CTRL_TRIG_FALL]),
        .edgePulse(trigEdge)
    );

    // sync input counts rising edges; 50 kHz leaves 2000 clocks per period
    adsq_edge_detect uSync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .levelIn(syncIn),
        .fallingSel(1'b0),
        .edgePulse(syncEdge)
    );

    // pacer select: internal divider or sync pin, first external pulse dropped
    // only in continuous mode so the converter setup completes
    assign tick = ctrl_q[`ADSQ_CTRL_EXT_PACER] ?
        (syncEdge & (firstSeen_q | ctrl_q[`ADSQ_CTRL_GATED])) : intTick;

    // ==================================================
    // bus slave: reads answered with zero wait from the address phase
    always @* begin
        rdAddr = haddr[7:0];
        rdData = 32'h0000_0000;
        if (rdAddr[`ADSQ_LIST_SEL_MSB:`ADSQ_LIST_SEL_LSB] == `ADSQ_LIST_SEL) begin
            rdData = {25'h0000000, listMem[rdAddr[5:2]]};
        end else begin
            case (rdAddr)
                `ADSQ_OFF_CTRL: rdData = {26'h0000000, ctrl_q, 1'b0};
                `ADSQ_OFF_PACER: rdData = {16'h0000, pacerDiv_q};
                `ADSQ_OFF_COUNT: rdData = {16'h0000, total_q};
                `ADSQ_OFF_LISTLEN: rdData = {28'h0000000, listLast_q};
                `ADSQ_OFF_STATUS: rdData = {done_q, 4'h0, ptr_q, 5'h00, state_q};
                `ADSQ_OFF_LAST: rdData = {16'h0000, last_q};
                default: rdData = 32'h0000_0000;
            endcase
        end
    end

    // address capture, read data, write data applied in the data phase
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
            wrPend_q <= 1'b0;
            wrAddr_q <= 8'h00;
            startReq_q <= 1'b0;
            abortReq_q <= 1'b0;
            ctrl_q <= {(`ADSQ_CTRL_W-1){1'b0}};
            pacerDiv_q <= `ADSQ_PACER_RST;
            total_q <= `ADSQ_COUNT_RST;
            listLast_q <= 4'h0;
        end else begin
            wrPend_q <= addrPhase & hwrite;
            startReq_q <= 1'b0;
            abortReq_q <= 1'b0;
            if (addrPhase) begin
                wrAddr_q <= haddr[7:0];
                hrdata <= hwrite ? 32'h0000_0000 : rdData;
            end
            if (wrPend_q) begin
                case (wrAddr_q)
                    `ADSQ_OFF_CTRL: begin
                        ctrl_q <= hwdata[`ADSQ_CTRL_W-1:1];
                        startReq_q <= hwdata[`ADSQ_CTRL_START];
                        abortReq_q <= hwdata[`ADSQ_CTRL_ABORT];
                    end
                    `ADSQ_OFF_PACER: pacerDiv_q <= hwdata[15:0];
                    `ADSQ_OFF_COUNT: total_q <= hwdata[15:0];
                    `ADSQ_OFF_LISTLEN: listLast_q <= hwdata[3:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // list memory: any channel and range per entry, repeats allowed
    always @(posedge clk_sys) begin
        if (wrPend_q &&
            wrAddr_q[`ADSQ_LIST_SEL_MSB:`ADSQ_LIST_SEL_LSB] == `ADSQ_LIST_SEL) begin
            listMem[wrAddr_q[5:2]] <= hwdata[`ADSQ_ENT_W-1:0];
        end
    end

    // ==================================================
    // internal pacer and sync pin; pacer drives the pin until told otherwise
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            pacerCnt_q <= `ADSQ_PACER_RST;
            syncOut <= 1'b0;
            syncOeN <= 1'b0;
        end else begin
            pacerCnt_q <= intTick ? pacerDiv_q : pacerCnt_q - 16'h0001;
            syncOut <= (pacerCnt_q > {1'b0, pacerDiv_q[15:1]});
            syncOeN <= ctrl_q[`ADSQ_CTRL_EXT_PACER];
        end
    end

    // ==================================================
    // saturating conversion to the 12-bit offset code
    always @* begin
        sum = adcRaw + `ADSQ_CODE_MID;
        if (adcRaw > (`ADSQ_CODE_MAX - `ADSQ_CODE_MID)) begin
            sum = `ADSQ_CODE_MAX;
        end else if (adcRaw < (`ADSQ_CODE_MIN - `ADSQ_CODE_MID)) begin
            sum = `ADSQ_CODE_MIN;
        end
    end

    // ==================================================
    // scan state machine; a tick arriving while the store waits on a full buffer is lost,
    // the buffer only stalls the store, never a conversion in flight
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            ptr_q <= 4'h0;
            done_q <= 16'h0000;
            firstSeen_q <= 1'b0;
            adcStart <= 1'b0;
            adcChannel <= 3'h0;
            adcRange <= `ADSQ_RANGE_BIPOLAR_TEN_VOLT;
            code_q <= 12'h000;
            last_q <= 16'h0000;
        end else begin
            adcStart <= 1'b0;
            if (ctrl_q[`ADSQ_CTRL_EXT_PACER] && syncEdge) begin
                firstSeen_q <= 1'b1;
            end
            if (abortReq_q) begin
                state_q <= ST_IDLE;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        if (startReq_q) begin
                            ptr_q <= 4'h0;
                            done_q <= 16'h0000;
                            // a sync pulse landing with the start is the dropped first one
                            firstSeen_q <= syncEdge & ctrl_q[`ADSQ_CTRL_EXT_PACER];
                            state_q <= ctrl_q[`ADSQ_CTRL_TRIG_EN] ? ST_ARM : ST_TICK;
                            adcChannel <= listMem[0][`ADSQ_CH_MSB:0];
                            adcRange <= listMem[0][`ADSQ_RANGE_MSB:`ADSQ_RANGE_LSB];
                        end
                    end
                    ST_ARM: begin
                        if (trigEdge) begin
                            state_q <= ST_TICK;
                        end
                    end
                    ST_TICK: begin
                        if (tick) begin
                            adcStart <= 1'b1;
                            state_q <= ST_CONV;
                        end
                    end
                    ST_CONV: begin
                        if (adcDone) begin
                            code_q <= sum[11:0];
                            state_q <= ST_STORE;
                        end
                    end
                    ST_STORE: begin
                        if (bufReady) begin
                            last_q <= {ptr_q, code_q};
                            done_q <= done_q + 16'h0001;
                            if (done_q + 16'h0001 == total_q) begin
                                state_q <= ST_IDLE;
                            end else begin
                                state_q <= ST_TICK;
                            end
                            if (ctrl_q[`ADSQ_CTRL_LIST_EN]) begin
                                ptr_q <= nextPtr;
                                adcChannel <= listMem[nextPtr][`ADSQ_CH_MSB:0];
                                adcRange <= listMem[nextPtr][`ADSQ_RANGE_MSB:`ADSQ_RANGE_LSB];
                            end else begin
                                adcChannel <= curEnt[`ADSQ_CH_MSB:0];
                                adcRange <= curEnt[`ADSQ_RANGE_MSB:`ADSQ_RANGE_LSB];
                            end
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // ==================================================
    // output buffer so a stalled receiver loses no sample
    adsq_buffer2 #(
        .WIDTH(16)
    ) uBuf (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .inValid(state_q == ST_STORE),
        .inData({ptr_q, code_q}),
        .inReady(bufReady),
        .outValid(sampleValid),
        .outData(sampleData),
        .outReady(sampleReady)
    );
endmodule // adsq_sequencer

`default_nettype wire

/* inc/adsq_defs.vh */
// constants for the scan list sequencer: register offsets, fields, reset values
// assumes a 32-bit AHB-Lite register bus and a 100 MHz system clock
`ifndef ADSQ_DEFS_VH
`define ADSQ_DEFS_VH

// ==================================================
// register byte offsets
`define ADSQ_OFF_CTRL 8'h00
`define ADSQ_OFF_PACER 8'h04
`define ADSQ_OFF_COUNT 8'h08
`define ADSQ_OFF_LISTLEN 8'h0c
`define ADSQ_OFF_STATUS 8'h10
`define ADSQ_OFF_LAST 8'h14
`define ADSQ_OFF_LIST 8'h40
`define ADSQ_LIST_SEL_MSB 7
`define ADSQ_LIST_SEL_LSB 6
`define ADSQ_LIST_SEL 2'h1

// ==================================================
// control fields
`define ADSQ_CTRL_START 0
`define ADSQ_CTRL_TRIG_EN 1
`define ADSQ_CTRL_TRIG_FALL 2
`define ADSQ_CTRL_EXT_PACER 3
`define ADSQ_CTRL_GATED 4
`define ADSQ_CTRL_LIST_EN 5
`define ADSQ_CTRL_ABORT 6
`define ADSQ_CTRL_W 6

// ==================================================
// list entry layout: channel [2:0], range [6:4]
`define ADSQ_ENT_W 7
`define ADSQ_CH_MSB 2
`define ADSQ_RANGE_MSB 6
`define ADSQ_RANGE_LSB 4
`define ADSQ_RANGE_BIPOLAR_TEN_VOLT 3'h1
`define ADSQ_RANGE_BIPOLAR_FIVE_VOLT 3'h2
`define ADSQ_RANGE_BIPOLAR_ONE_VOLT 3'h7

// ==================================================
// reset values and conversion code limits
`define ADSQ_PACER_RST 16'h07cf
`define ADSQ_COUNT_RST 16'h0010
`define ADSQ_CODE_MID 14'sh0800
`define ADSQ_CODE_MAX 14'sh0fff
`define ADSQ_CODE_MIN 14'sh0000

`endif

/* verification/adsq_adc_model.sv */
// converter model: answers each start with one done pulse and a raw value
// assumes the selection is steady at the start pulse; slowMode stretches the answer
`timescale 1ns/10ps
`default_nettype none

// ==================================================
// converter model
module adsq_adc_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // request side
    input wire logic adcStart,
    input wire logic [2:0] adcChannel,
    input wire logic [2:0] adcRange,
    input wire logic slowMode,
    // answer side
    output logic adcDone,
    output logic signed [13:0] adcRaw
);
    logic busy_q;
    logic [4:0] wait_q;
    logic signed [13:0] held_q;

    // range code 7 drives the input far past either end of the scale
    function automatic logic signed [13:0] rawOf(input logic [2:0] ch, input logic [2:0] rg);
        if (rg == 3'h7) begin
            return ch[0] ? 14'sh0bb8 : -14'sh0bb8;
        end
        return $signed({11'h0, ch}) * 14'sh00c8 - $signed({11'h0, rg}) * 14'sh0064;
    endfunction

    // raw value toggles outside done so stale data never looks valid
    always @(posedge clk_sys) begin
        adcDone <= 1'b0;
        adcRaw <= ~adcRaw;
        if (sys_rst) begin
            busy_q <= 1'b0;
            adcRaw <= 14'sh0000;
        end else if (adcStart) begin
            busy_q <= 1'b1;
            wait_q <= slowMode ? 5'h0c : 5'h01;
            held_q <= rawOf(adcChannel, adcRange);
        end else if (busy_q && wait_q == 5'h00) begin
            busy_q <= 1'b0;
            adcDone <= 1'b1;
            adcRaw <= held_q;
        end else if (busy_q) begin
            wait_q <= wait_q - 5'h01;
        end
    end
endmodule // adsq_adc_model
`default_nettype wire

/* verification/adsq_seq_asserts.sv */
// checker: concurrent assertions on the sequencer's converter, pin and stream ports
// assumes one clock, clk_sys, and an active high synchronous sys_rst
`timescale 1ns/10ps
`default_nettype none

// ==================================================
// checker module
module adsq_seq_asserts (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // sync pin and converter
    input wire logic syncOeN,
    input wire logic [2:0] adcChannel,
    input wire logic [2:0] adcRange,
    input wire logic adcStart,
    input wire logic adcDone,
    input wire logic signed [13:0] adcRaw,
    // sample stream
    input wire logic sampleValid,
    input wire logic [15:0] sampleData,
    input wire logic sampleReady
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    logic signed [14:0] sumC;
    logic [11:0] expC;
    logic [3:0] lastIdx_q;

    // expected code from the raw value, clamped so over range never wraps
    always @* begin
        sumC = adcRaw + 15'sh0800;
        expC = (sumC < 0) ? 12'h000 : ((sumC > 15'sh0fff) ? 12'hfff : sumC[11:0]);
    end

    // index of the last sample taken from the stream
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            lastIdx_q <= 4'hf;
        end else if (sampleValid && sampleReady) begin
            lastIdx_q <= sampleData[15:12];
        end
    end

    // no second start before the converter has answered
    sequence sConvQuiet;
        (!adcStart) throughout (##[0:40] adcDone);
    endsequence
    // an empty buffer shows the new sample two cycles after the answer
    sequence sStoreDelay;
        ##2 sampleValid;
    endsequence

    AST_SYNC_DRIVES: assert property ($fell(sys_rst) |-> !syncOeN)
        else $error("sync pin not driven after reset");
    AST_START_PULSE: assert property (adcStart |=> !adcStart)
        else $error("start wider than one cycle");
    AST_CONV_QUIET: assert property (adcStart |=> sConvQuiet)
        else $error("start during a conversion");
    AST_SEL_HOLD: assert property (adcStart |-> ##1 ($stable(adcChannel) && $stable(adcRange)))
        else $error("selection moved during conversion");
    AST_VALID_HOLD: assert property (sampleValid && !sampleReady |=> sampleValid && $stable(sampleData))
        else $error("stalled sample lost or changed");
    AST_STORE_DELAY: assert property (adcDone && !sampleValid |-> sStoreDelay)
        else $error("sample not stored on time");
    AST_CODE: assert property (adcDone && !sampleValid |-> ##2 (sampleData[11:0] == $past(expC, 2)))
        else $error("sample code wrong");
    AST_IDX_STEP: assert property (sampleValid && sampleReady
        |-> (sampleData[15:12] == lastIdx_q + 4'h1) || (sampleData[15:12] == 4'h0))
        else $error("list index skipped");
endmodule // adsq_seq_asserts

bind adsq_sequencer adsq_seq_asserts u_asserts (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .syncOeN(syncOeN), .adcChannel(adcChannel), .adcRange(adcRange), .adcStart(adcStart),
    .adcDone(adcDone), .adcRaw(adcRaw), .sampleValid(sampleValid), .sampleData(sampleData),
    .sampleReady(sampleReady));
`default_nettype wire

/* verification/adsq_sequencer_tb_top.sv */
// testbench: list scans, trigger polarity and external pacing through the register bus
// assumes the sequencer and the converter model; one 100 MHz clock
`include "adsq_defs.vh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin failures++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

// ==================================================
// bench top
module adsq_sequencer_tb_top;
    logic clk_sys, sys_rst, hsel, hwrite, extTrig, syncIn, sampleReady, slowMode;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, rd, lfsr, rdyRnd;
    wire hreadyout, hresp, syncOut, syncOeN, adcStart, adcDone, sampleValid;
    wire [31:0] hrdata;
    wire [2:0] adcChannel, adcRange;
    wire signed [13:0] adcRaw;
    wire [15:0] sampleData;
    logic [2:0] listCh[16], listRg[16];
    logic listOn, stallAll, syncPrev;
    int failures, checks_done, cycles, listLen, startCnt, sampCnt, syncEdges, eIdx, cnt;
    logic [7:0] rA[5] = '{`ADSQ_OFF_CTRL, `ADSQ_OFF_PACER, `ADSQ_OFF_COUNT, `ADSQ_OFF_LISTLEN, 8'h20};
    logic [31:0] rE[5] = '{32'h0, 32'h07cf, 32'h0010, 32'h0, 32'h0};

    adsq_sequencer u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ext_trigger_input(extTrig),
        .syncIn(syncIn), .syncOut(syncOut), .syncOeN(syncOeN), .adcChannel(adcChannel),
        .adcRange(adcRange), .adcStart(adcStart), .adcDone(adcDone), .adcRaw(adcRaw),
        .sampleValid(sampleValid), .sampleData(sampleData), .sampleReady(sampleReady));
    adsq_adc_model u_adc (.clk_sys(clk_sys), .sys_rst(sys_rst), .adcStart(adcStart),
        .adcChannel(adcChannel), .adcRange(adcRange), .slowMode(slowMode), .adcDone(adcDone),
        .adcRaw(adcRaw));

    function automatic logic [31:0] nextRand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // code the converter model's raw value should turn into
    function automatic logic [11:0] expCode(input logic [2:0] ch, input logic [2:0] rg);
        int v;
        v = (rg == 3'h7) ? (ch[0] ? 3000 : -3000) : ch * 200 - rg * 100;
        v = v + 2048;
        return (v < 0) ? 12'h000 : ((v > 4095) ? 12'hfff : v[11:0]);
    endfunction

    // clock, and a ceiling on the whole run
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            give_verdict();
        end
    end

    task give_verdict;
        if (failures == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // one single transfer; called just after a rising edge
    task busXfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        rd = hrdata;
        `CHK("bus response", 1'b0, hresp);
    endtask
    // poll until the scan is over, then let the buffer drain
    task waitIdle;
        int n;
        n = 0;
        repeat (2) @(posedge clk_sys);
        busXfer(1'b0, `ADSQ_OFF_STATUS, 32'h0);
        while (rd[2:0] !== 3'h0 && n < 3000) begin
            busXfer(1'b0, `ADSQ_OFF_STATUS, 32'h0);
            n++;
        end
        `CHK("scan idle", 3'h0, rd[2:0]);
        repeat (40) @(posedge clk_sys);
    endtask

    // random stalls on the stream, and the monitor of starts and samples
    always @(posedge clk_sys) begin
        rdyRnd <= nextRand(rdyRnd);
        sampleReady <= !stallAll && rdyRnd[0];
        syncPrev <= syncOut;
        if (syncOut !== syncPrev) syncEdges++;
        if (adcStart === 1'b1) begin
            eIdx = listOn ? startCnt % listLen : 0;
            `CHK("channel", listCh[eIdx], adcChannel);
            `CHK("range", listRg[eIdx], adcRange);
            startCnt++;
        end
        if (sampleValid === 1'b1 && sampleReady) begin
            eIdx = listOn ? sampCnt % listLen : 0;
            `CHK("index", eIdx[3:0], sampleData[15:12]);
            `CHK("code", expCode(listCh[eIdx], listRg[eIdx]), sampleData[11:0]);
            sampCnt++;
        end
    end

    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, extTrig, syncIn, sampleReady, slowMode} = '0;
        {listOn, stallAll} = 2'b00;
        {failures, checks_done, cycles, startCnt, sampCnt, syncEdges} = '0;
        listLen = 1;
        lfsr = 32'hb984;
        rdyRnd = 32'hb984;
        sys_rst = 1'b1;
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        `CHK("sync dir", 1'b0, syncOeN);
        `CHK("reset range", 3'h1, adcRange);
        for (int i = 0; i < 5; i++) begin
            busXfer(1'b0, rA[i], 32'h0);
            `CHK("reset reg", rE[i], rd);
        end
        // fixed list with repeats and over range, then sixteen random, then list off
        for (int run = 0; run < 3; run++) begin
            listLen = (run == 0) ? 5 : 16;
            listOn = (run != 2);
            slowMode = (run == 1);
            for (int i = 0; i < listLen; i++) begin
                lfsr = nextRand(lfsr);
                listCh[i] = (run == 0) ? 3'(((32'h7270 >> (4 * i)) & 7) | (i == 4 ? 7 : 0)) : lfsr[2:0];
                listRg[i] = (run == 0) ? 3'((32'h71217 >> (4 * i)) & 7) : lfsr[6:4];
                busXfer(1'b1, 8'(`ADSQ_OFF_LIST + 4 * i), {25'h0, listRg[i], 1'b0, listCh[i]});
            end
            cnt = 2 * listLen + 3;
            busXfer(1'b1, `ADSQ_OFF_LISTLEN, 32'(listLen - 1));
            busXfer(1'b1, `ADSQ_OFF_COUNT, 32'(cnt));
            busXfer(1'b1, `ADSQ_OFF_PACER, 32'(3 - run));
            {startCnt, sampCnt, syncEdges} = '0;
            stallAll = (run == 1);
            busXfer(1'b1, `ADSQ_OFF_CTRL, listOn ? 32'h21 : 32'h01);
            repeat (80) @(posedge clk_sys);
            stallAll = 1'b0;
            waitIdle();
            `CHK("samples", cnt, sampCnt);
            `CHK("starts", cnt, startCnt);
            `CHK("sync toggles", 1'b1, syncEdges > 0);
            busXfer(1'b0, `ADSQ_OFF_STATUS, 32'h0);
            `CHK("done count", cnt[15:0], rd[31:16]);
            busXfer(1'b0, `ADSQ_OFF_LAST, 32'h0);
            cnt = listOn ? (cnt - 1) % listLen : 0;
            `CHK("last sample", {cnt[3:0], expCode(listCh[cnt], listRg[cnt])}, rd[15:0]);
        end
        // trigger: the opposite edge is ignored, the selected one starts the scan
        busXfer(1'b1, `ADSQ_OFF_COUNT, 32'h2);
        for (int f = 0; f < 2; f++) begin
            extTrig <= !f;
            repeat (5) @(posedge clk_sys);
            {startCnt, sampCnt} = '0;
            busXfer(1'b1, `ADSQ_OFF_CTRL, f ? 32'h07 : 32'h03);
            repeat (10) @(posedge clk_sys);
            extTrig <= f;
            repeat (10) @(posedge clk_sys);
            busXfer(1'b0, `ADSQ_OFF_STATUS, 32'h0);
            `CHK("armed", 3'h1, rd[2:0]);
            `CHK("no start", 0, startCnt);
            extTrig <= !f;
            waitIdle();
            `CHK("trig samples", 2, sampCnt);
        end
        // external pacing at 50 kHz, continuous then gated
        busXfer(1'b1, `ADSQ_OFF_COUNT, 32'h10);
        for (int g = 0; g < 2; g++) begin
            busXfer(1'b1, `ADSQ_OFF_CTRL, g ? 32'h19 : 32'h09);
            repeat (5) @(posedge clk_sys);
            `CHK("sync input", 1'b1, syncOeN);
            startCnt = 0;
            repeat (3) begin
                syncIn <= 1'b1;
                repeat (1000) @(posedge clk_sys);
                syncIn <= 1'b0;
                repeat (1000) @(posedge clk_sys);
            end
            `CHK("ext starts", 2 + g, startCnt);
            busXfer(1'b1, `ADSQ_OFF_CTRL, 32'h40);
            waitIdle();
        end
        give_verdict();
    end
endmodule // adsq_sequencer_tb_top
`default_nettype wire
